// >>> pfs_pin_mux.sv
// port-0 pin function multiplexer with its two select registers on ahb-lite
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module pfs_pin_mux
    import pfs_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // general-purpose i/o logic
    input  wire logic [NUM_PINS-1:0]  gpioOut,
    input  wire logic [NUM_PINS-1:0]  gpioDirectionBits,
    output logic      [NUM_PINS-1:0]  gpioIn,
    // peripheral signals, indexed by function code
    input  wire logic [NUM_FN-1:0]    perOut,
    input  wire logic [NUM_FN-1:0]    perOe,
    output logic      [NUM_FN-1:0]    perIn,
    // package pins
    input  wire logic [NUM_PINS-1:0]  pinIn,
    output logic      [NUM_PINS-1:0]  pinOut,
    output logic      [NUM_PINS-1:0]  pinOe
);

    logic [31:0]          pinSelectLow;
    logic [31:0]          pinSelectHigh;
    logic [63:0]          selAll;
    pfs_ahb_phase_t       dphase;
    logic [31:0]          next_hrdata;
    logic [NUM_PINS-1:0]  pinMeta;
    logic [NUM_PINS-1:0]  pinSync;
    logic [NUM_PINS-1:0]  next_pinOut;
    logic [NUM_PINS-1:0]  next_pinOe;
    logic [NUM_FN-1:0]    next_perIn;
    logic                 addrPhase;

    assign selAll    = {pinSelectHigh, pinSelectLow};
    assign addrPhase = hsel && htrans[1] && hready;

    // function selected for one pin by the current select fields
    function automatic pfs_fn_t pinFn(input int unsigned pin, input logic [63:0] sel);
        logic [1:0] code;
        code = sel[2*pin +: 2];
        return PIN_MAP[pin][code];
    endfunction : pinFn

    // ---------------- ahb-lite slave ----------------

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dphase <= '0;
        end else if (hready) begin
            dphase.active <= hsel && htrans[1];
            dphase.write  <= hwrite;
            dphase.addr   <= haddr;
        end
    end

    // only whole-word access is supported, so hsize is not decoded
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinSelectLow  <= PIN_SELECT_LOW_RST;
            pinSelectHigh <= PIN_SELECT_HIGH_RST;
        end else if (dphase.active && dphase.write) begin
            if (dphase.addr == PIN_SELECT_LOW_ADDR) begin
                pinSelectLow <= hwdata;
            end
            if (dphase.addr == PIN_SELECT_HIGH_ADDR) begin
                pinSelectHigh <= hwdata;
            end
        end
    end

    // a write still in its data phase is forwarded so a back-to-back read sees it
    always_comb begin
        next_hrdata = 32'h00000000;
        if (haddr == PIN_SELECT_LOW_ADDR) begin
            next_hrdata = pinSelectLow;
        end else if (haddr == PIN_SELECT_HIGH_ADDR) begin
            next_hrdata = pinSelectHigh;
        end
        if (dphase.active && dphase.write && dphase.addr == haddr &&
            (haddr == PIN_SELECT_LOW_ADDR || haddr == PIN_SELECT_HIGH_ADDR)) begin
            next_hrdata = hwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

    // zero wait states, always okay
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ---------------- pin side ----------------

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
            pfs_fn_t fn;
            assign fn = pinFn(i, selAll);
            always_comb begin
                if (fn == FN_GPIO) begin
                    next_pinOut[i] = gpioOut[i];
                    next_pinOe[i]  = gpioDirectionBits[i];
                end else if (fn == FN_RSVD) begin
                    next_pinOut[i] = 1'b0;
                    next_pinOe[i]  = 1'b0;
                end else begin
                    next_pinOut[i] = perOut[fn];
                    next_pinOe[i]  = perOe[fn];
                end
            end
        end
    endgenerate

    // inputs shared by several pins are ored; an unrouted input reads low
    always_comb begin
        pfs_fn_t f;
        f = FN_RSVD;
        next_perIn = '0;
        for (int unsigned i = 0; i < NUM_PINS; i++) begin
            f = pinFn(i, selAll);
            if (f != FN_RSVD && f != FN_GPIO) begin
                next_perIn[f] = next_perIn[f] | pinSync[i];
            end
        end
    end

    // the gpio input register sees every pin level whatever its function
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinOut <= '0;
            pinOe  <= '0;
            perIn  <= '0;
            gpioIn <= '0;
        end else begin
            pinOut <= next_pinOut;
            pinOe  <= next_pinOe;
            perIn  <= next_perIn;
            gpioIn <= pinSync;
        end
    end

    // ---------------- checks ----------------

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_reset_values: assert property (
        disable iff (1'b0)
        !reset_n |=> pinSelectLow == 32'h00000000 && pinSelectHigh == 32'h05400000
    ) else $error("select registers wrong after reset");

    a_low_write: assert property (
        addrPhase && hwrite && haddr == PIN_SELECT_LOW_ADDR
        ##1 hready |=> pinSelectLow == $past(hwdata)
    ) else $error("low select write not stored");

    a_high_readback: assert property (
        addrPhase && !hwrite && haddr == PIN_SELECT_HIGH_ADDR
        && !(dphase.active && dphase.write) |=> hrdata == $past(pinSelectHigh)
    ) else $error("high select read back wrong");

    a_gpio_dir: assert property (
        pinSelectLow[1:0] == 2'b00 |=> pinOe[0] == $past(gpioDirectionBits[0])
    ) else $error("pin 0 direction not from gpio");

    a_periph_dir: assert property (
        pinSelectLow[1:0] == 2'b01 |=>
        pinOe[0] == $past(perOe[FN_S0TX]) && pinOut[0] == $past(perOut[FN_S0TX])
    ) else $error("pin 0 not driven by serial transmit");

    a_irq_route: assert property (
        pinSelectLow[3:2] == 2'b11 && pinSync[1] |=> perIn[FN_XIR0]
    ) else $error("pin 1 level missing on interrupt line 0");

    a_match_route: assert property (
        pinSelectHigh[1:0] == 2'b10 |=> pinOut[16] == $past(perOut[FN_T0M2])
    ) else $error("pin 16 not driven by timer 0 match 2");

    a_rsvd_idle: assert property (
        pinSelectHigh[15:14] == 2'b10 |=> !pinOe[23]
    ) else $error("pin 23 driven under reserved code");

    a_can_tx: assert property (
        pinSelectHigh[17:16] == 2'b01 |=> pinOut[24] == $past(perOut[FN_C2TX])
    ) else $error("pin 24 not driven by can2 transmit");

    a_can_rx: assert property (
        pinSelectHigh[19:18] == 2'b01 && pinSync[25] |=> perIn[FN_C1RX]
    ) else $error("pin 25 not routed to can1 receive");

    a_analog_route: assert property (
        pinSelectHigh[29:28] == 2'b01 && pinSync[30] |=> perIn[FN_ANA3]
    ) else $error("pin 30 not routed to analog input 3");

    a_capture_route: assert property (
        pinSelectHigh[29:28] == 2'b11 && pinSync[30] |=> perIn[FN_T0C0]
    ) else $error("pin 30 not routed to capture 0");

    a_pin31_idle: assert property (
        1'b1 |=> !pinOe[31] && !pinOe[26]
    ) else $error("reserved pin driven");

    a_bus_okay: assert property (
        1'b1 |=> hreadyout && !hresp
    ) else $error("bus response not ready and okay");

    a_low_readback: assert property (
        addrPhase && !hwrite && haddr == PIN_SELECT_LOW_ADDR
        && !(dphase.active && dphase.write) |=> hrdata == $past(pinSelectLow)
    ) else $error("low select read back wrong");

    a_high_write: assert property (
        addrPhase && hwrite && haddr == PIN_SELECT_HIGH_ADDR
        ##1 hready |=> pinSelectHigh == $past(hwdata)
    ) else $error("high select write not stored");

    a_unmapped_read: assert property (
        addrPhase && !hwrite && haddr != PIN_SELECT_LOW_ADDR
        && haddr != PIN_SELECT_HIGH_ADDR |=> hrdata == 32'h00000000
    ) else $error("unmapped read not zero");

    a_write_forward: assert property (
        addrPhase && !hwrite && dphase.active && dphase.write
        && dphase.addr == haddr && haddr == PIN_SELECT_LOW_ADDR |=> hrdata == $past(hwdata)
    ) else $error("pending write not forwarded to read");

    a_low_hold: assert property (
        !(dphase.active && dphase.write) |=> $stable(pinSelectLow)
    ) else $error("low select changed without write");

    a_high_hold: assert property (
        !(dphase.active && dphase.write) |=> $stable(pinSelectHigh)
    ) else $error("high select changed without write");

    a_pulse_width_output_1_route: assert property (
        pinSelectLow[1:0] == 2'b10 |=>
        pinOe[0] == $past(perOe[FN_PWO1]) && pinOut[0] == $past(perOut[FN_PWO1])
    ) else $error("pin 0 not driven by pulse output 1");

    a_pin0_rsvd: assert property (
        pinSelectLow[1:0] == 2'b11 |=> !pinOe[0] && !pinOut[0]
    ) else $error("pin 0 driven under reserved code");

    a_pin1_gpio: assert property (
        pinSelectLow[3:2] == 2'b00 |=>
        pinOe[1] == $past(gpioDirectionBits[1]) && pinOut[1] == $past(gpioOut[1])
    ) else $error("pin 1 not under gpio control");

    a_rx_route: assert property (
        pinSelectLow[3:2] == 2'b01 && pinSync[1] |=> perIn[FN_S0RX]
    ) else $error("pin 1 not routed to serial receive");

    a_pulse_width_output_3_dir: assert property (
        pinSelectLow[3:2] == 2'b10 |=> pinOe[1] == $past(perOe[FN_PWO3])
    ) else $error("pin 1 direction not from pulse output 3");

    a_scl_dir: assert property (
        pinSelectLow[5:4] == 2'b01 |=> pinOe[2] == $past(perOe[FN_SCL])
    ) else $error("pin 2 direction not from serial clock");

    a_pin16_gpio: assert property (
        pinSelectHigh[1:0] == 2'b00 |=> pinOe[16] == $past(gpioDirectionBits[16])
    ) else $error("pin 16 direction not from gpio");

    a_ext_route: assert property (
        pinSelectHigh[1:0] == 2'b01 && pinSync[16] |=> perIn[FN_XIR0]
    ) else $error("pin 16 level missing on interrupt line 0");

    a_cap2_route: assert property (
        pinSelectHigh[1:0] == 2'b11 && pinSync[16] |=> perIn[FN_T0C2]
    ) else $error("pin 16 not routed to capture 2");

    a_can2_rx: assert property (
        pinSelectHigh[15:14] == 2'b01 && pinSync[23] |=> perIn[FN_C2RX]
    ) else $error("pin 23 not routed to can2 receive");

    a_can2_dir: assert property (
        pinSelectHigh[17:16] == 2'b01 |=> pinOe[24] == $past(perOe[FN_C2TX])
    ) else $error("pin 24 direction not from can2 transmit");

    a_pin24_rsvd: assert property (
        pinSelectHigh[17] |=> !pinOe[24] && !pinOut[24]
    ) else $error("pin 24 driven under reserved code");

    a_pin25_rsvd: assert property (
        pinSelectHigh[19] |=> !pinOe[25] && !pinOut[25]
    ) else $error("pin 25 driven under reserved code");

    a_can1_dir: assert property (
        pinSelectHigh[19:18] == 2'b01 |=> pinOe[25] == $past(perOe[FN_C1RX])
    ) else $error("pin 25 direction not from can1 receive");

    a_analog_start: assert property (
        pinSelectHigh[23:22] == 2'b01 && pinSync[27] |=> perIn[FN_ANA0]
    ) else $error("pin 27 not routed to analog input 0");

    a_analog_dir: assert property (
        pinSelectHigh[29:28] == 2'b01 |=> pinOe[30] == $past(perOe[FN_ANA3])
    ) else $error("pin 30 direction not from analog input 3");

    a_pin30_rsvd: assert property (
        pinSelectHigh[29:28] == 2'b10 |=> !pinOe[30] && !pinOut[30]
    ) else $error("pin 30 driven under reserved code");

    a_capture_dir: assert property (
        pinSelectHigh[29:28] == 2'b11 |=> pinOe[30] == $past(perOe[FN_T0C0])
    ) else $error("pin 30 direction not from capture 0");

    a_rsvd_out: assert property (
        1'b1 |=> !pinOut[31] && !pinOut[26]
    ) else $error("reserved pin output not low");

    a_no_code_in: assert property (
        1'b1 |=> !perIn[FN_RSVD] && !perIn[FN_GPIO]
    ) else $error("unused peripheral input bits set");

    c_write_low: cover property (addrPhase && hwrite && haddr == PIN_SELECT_LOW_ADDR);
    c_read_high: cover property (addrPhase && !hwrite && haddr == PIN_SELECT_HIGH_ADDR);
    c_capture_pin: cover property (pinSelectHigh[29:28] == 2'b11 ##1 perIn[FN_T0C0]);
    c_gpio_drive: cover property (pinSelectLow[1:0] == 2'b00 && pinOe[0]);
    c_reserved_pin: cover property (pinSelectLow[1:0] == 2'b11 ##1 !pinOe[0]);

endmodule : pfs_pin_mux

// >>> pfs_pkg.sv
// constants, function codes and pin table of the port-0 pin function multiplexer
// Contract
// - low select register: pins 0-15, two bits each
// - high select register: pins 16-31, two bits each
// - gpio direction applies only when gpio selected
// - peripheral selection sets pin direction automatically
// - pin 0 and pin 1 codes decoded as listed
// - pin 16 codes decoded as listed
// - pin 23 code 01 is can2 receive
// - pin 24 code 01 is can2 transmit
// - pin 25 field at 19:18, can1 receive
// - pin 30 code 01 is analog input 3
// - pin 30 code 11 is timer 0 capture 0
// - pin 31 field is reserved, selects nothing
// - fields reset to defined values, mostly gpio
// - both registers read and write whole words
package pfs_pkg;

    localparam int NUM_PINS = 32;

    localparam logic [31:0] PIN_SELECT_LOW_ADDR  = 32'he002c000;
    localparam logic [31:0] PIN_SELECT_HIGH_ADDR = 32'he002c004;
    localparam logic [31:0] PIN_SELECT_LOW_RST   = 32'h00000000;
    // pins 27..29 come up as analog inputs
    localparam logic [31:0] PIN_SELECT_HIGH_RST  = 32'h05400000;

    typedef logic [5:0] pfs_fn_t;

    // 0 = nothing driven, 1 = gpio, 2.. = peripheral signal index
    localparam pfs_fn_t FN_RSVD  = 6'h00;
    localparam pfs_fn_t FN_GPIO  = 6'h01;
    localparam pfs_fn_t FN_S0TX  = 6'h02;
    localparam pfs_fn_t FN_S0RX  = 6'h03;
    localparam pfs_fn_t FN_PWO1  = 6'h04;
    localparam pfs_fn_t FN_PWO2  = 6'h05;
    localparam pfs_fn_t FN_PWO3  = 6'h06;
    localparam pfs_fn_t FN_PWO4  = 6'h07;
    localparam pfs_fn_t FN_PWO5  = 6'h08;
    localparam pfs_fn_t FN_PWO6  = 6'h09;
    localparam pfs_fn_t FN_XIR0  = 6'h0a;
    localparam pfs_fn_t FN_XIR1  = 6'h0b;
    localparam pfs_fn_t FN_XIR2  = 6'h0c;
    localparam pfs_fn_t FN_XIR3  = 6'h0d;
    localparam pfs_fn_t FN_SCL   = 6'h0e;
    localparam pfs_fn_t FN_SDA   = 6'h0f;
    localparam pfs_fn_t FN_SCK0  = 6'h10;
    localparam pfs_fn_t FN_MISO0 = 6'h11;
    localparam pfs_fn_t FN_MOSI0 = 6'h12;
    localparam pfs_fn_t FN_SSEL0 = 6'h13;
    localparam pfs_fn_t FN_SCK1  = 6'h14;
    localparam pfs_fn_t FN_MISO1 = 6'h15;
    localparam pfs_fn_t FN_MOSI1 = 6'h16;
    localparam pfs_fn_t FN_SSEL1 = 6'h17;
    localparam pfs_fn_t FN_T0C0  = 6'h18;
    localparam pfs_fn_t FN_T0C1  = 6'h19;
    localparam pfs_fn_t FN_T0C2  = 6'h1a;
    localparam pfs_fn_t FN_T0C3  = 6'h1b;
    localparam pfs_fn_t FN_T0M0  = 6'h1c;
    localparam pfs_fn_t FN_T0M1  = 6'h1d;
    localparam pfs_fn_t FN_T0M2  = 6'h1e;
    localparam pfs_fn_t FN_T0M3  = 6'h1f;
    localparam pfs_fn_t FN_T1C0  = 6'h20;
    localparam pfs_fn_t FN_T1C1  = 6'h21;
    localparam pfs_fn_t FN_T1C2  = 6'h22;
    localparam pfs_fn_t FN_T1C3  = 6'h23;
    localparam pfs_fn_t FN_T1M0  = 6'h24;
    localparam pfs_fn_t FN_T1M1  = 6'h25;
    localparam pfs_fn_t FN_T1M2  = 6'h26;
    localparam pfs_fn_t FN_T1M3  = 6'h27;
    localparam pfs_fn_t FN_S1TX  = 6'h28;
    localparam pfs_fn_t FN_S1RX  = 6'h29;
    localparam pfs_fn_t FN_RTS   = 6'h2a;
    localparam pfs_fn_t FN_CTS   = 6'h2b;
    localparam pfs_fn_t FN_DSR   = 6'h2c;
    localparam pfs_fn_t FN_DTR   = 6'h2d;
    localparam pfs_fn_t FN_DCD   = 6'h2e;
    localparam pfs_fn_t FN_RI    = 6'h2f;
    localparam pfs_fn_t FN_C2RX  = 6'h30;
    localparam pfs_fn_t FN_C2TX  = 6'h31;
    localparam pfs_fn_t FN_C1RX  = 6'h32;
    localparam pfs_fn_t FN_ANA0  = 6'h33;
    localparam pfs_fn_t FN_ANA1  = 6'h34;
    localparam pfs_fn_t FN_ANA2  = 6'h35;
    localparam pfs_fn_t FN_ANA3  = 6'h36;
    localparam int      NUM_FN   = 55;

    // row = pin, column = select code 00, 01, 10, 11
    localparam pfs_fn_t PIN_MAP [NUM_PINS][4] = '{
        '{FN_GPIO, FN_S0TX,  FN_PWO1,  FN_RSVD},
        '{FN_GPIO, FN_S0RX,  FN_PWO3,  FN_XIR0},
        '{FN_GPIO, FN_SCL,   FN_T0C0,  FN_RSVD},
        '{FN_GPIO, FN_SDA,   FN_T0M0,  FN_XIR1},
        '{FN_GPIO, FN_SCK0,  FN_T0C1,  FN_RSVD},
        '{FN_GPIO, FN_MISO0, FN_T0M1,  FN_RSVD},
        '{FN_GPIO, FN_MOSI0, FN_T0C2,  FN_RSVD},
        '{FN_GPIO, FN_SSEL0, FN_PWO2,  FN_XIR2},
        '{FN_GPIO, FN_S1TX,  FN_PWO4,  FN_RSVD},
        '{FN_GPIO, FN_S1RX,  FN_PWO6,  FN_XIR3},
        '{FN_GPIO, FN_RTS,   FN_T1C0,  FN_RSVD},
        '{FN_GPIO, FN_CTS,   FN_T1C1,  FN_RSVD},
        '{FN_GPIO, FN_DSR,   FN_T1M0,  FN_RSVD},
        '{FN_GPIO, FN_DTR,   FN_T1M1,  FN_RSVD},
        '{FN_GPIO, FN_DCD,   FN_XIR1,  FN_RSVD},
        '{FN_GPIO, FN_RI,    FN_XIR2,  FN_RSVD},
        '{FN_GPIO, FN_XIR0,  FN_T0M2,  FN_T0C2},
        '{FN_GPIO, FN_T1C2,  FN_SCK1,  FN_T1M2},
        '{FN_GPIO, FN_T1C3,  FN_MISO1, FN_T1M3},
        '{FN_GPIO, FN_T1M2,  FN_MOSI1, FN_T1C2},
        '{FN_GPIO, FN_T1M3,  FN_SSEL1, FN_XIR3},
        '{FN_GPIO, FN_PWO5,  FN_RSVD,  FN_T1C3},
        '{FN_GPIO, FN_RSVD,  FN_T0C0,  FN_T0M0},
        '{FN_GPIO, FN_C2RX,  FN_RSVD,  FN_RSVD},
        '{FN_GPIO, FN_C2TX,  FN_RSVD,  FN_RSVD},
        '{FN_GPIO, FN_C1RX,  FN_RSVD,  FN_RSVD},
        '{FN_RSVD, FN_RSVD,  FN_RSVD,  FN_RSVD},
        '{FN_GPIO, FN_ANA0,  FN_T0C1,  FN_T0M1},
        '{FN_GPIO, FN_ANA1,  FN_T0C2,  FN_T0M2},
        '{FN_GPIO, FN_ANA2,  FN_T0C3,  FN_T0M3},
        '{FN_GPIO, FN_ANA3,  FN_RSVD,  FN_T0C0},
        '{FN_RSVD, FN_RSVD,  FN_RSVD,  FN_RSVD}
    };

    // captured ahb address phase, used during the data phase
    typedef struct packed {
        logic        active;
        logic        write;
        logic [31:0] addr;
    } pfs_ahb_phase_t;

endpackage : pfs_pkg

// >>> pfs_periph_model.sv
// behavioural model of the peripherals and package pins around the port-0 mux
`timescale 1ns/1ps
module pfs_periph_model
    import pfs_pkg::*;
(
    // control from the bench
    input  wire logic                perActive,
    input  wire logic [NUM_FN-1:0]   drvFn,
    input  wire logic [NUM_PINS-1:0] extLevel,
    // mux side
    input  wire logic [NUM_PINS-1:0] pinOut,
    input  wire logic [NUM_PINS-1:0] pinOe,
    output logic      [NUM_FN-1:0]   perOut,
    output logic      [NUM_FN-1:0]   perOe,
    output logic      [NUM_PINS-1:0] pinIn
);
    // peripherals are switched on only after the bench has routed them
    assign perOe  = perActive ? drvFn : '0;
    // a driver sends a one, so a dead route shows up as a zero at the pin
    assign perOut = perOe;
    // an undriven pin shows what the board puts on it
    assign pinIn  = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : pfs_periph_model

// >>> tb_port0_pin_function_select.sv
// self-checking bench for the port-0 pin function multiplexer
`timescale 1ns/1ps
module tb_port0_pin_function_select;
    import pfs_pkg::*;
    typedef struct packed {
        logic [4:0] pin;
        logic [1:0] code;
        pfs_fn_t    fn;
        logic       drives;
    } pfs_case_t;
    // pin, code, function expected, peripheral drives the pin
    localparam pfs_case_t CASES [22] = '{
        '{5'd0, 2'd1, FN_S0TX, 1'b1}, '{5'd0, 2'd2, FN_PWO1, 1'b1},
        '{5'd0, 2'd3, FN_RSVD, 1'b0}, '{5'd1, 2'd1, FN_S0RX, 1'b0},
        '{5'd1, 2'd2, FN_PWO3, 1'b1}, '{5'd1, 2'd3, FN_XIR0, 1'b0},
        '{5'd16, 2'd1, FN_XIR0, 1'b0}, '{5'd16, 2'd2, FN_T0M2, 1'b1},
        '{5'd16, 2'd3, FN_T0C2, 1'b0}, '{5'd23, 2'd1, FN_C2RX, 1'b0},
        '{5'd23, 2'd2, FN_RSVD, 1'b0}, '{5'd24, 2'd1, FN_C2TX, 1'b1},
        '{5'd24, 2'd3, FN_RSVD, 1'b0}, '{5'd25, 2'd1, FN_C1RX, 1'b0},
        '{5'd30, 2'd1, FN_ANA3, 1'b0}, '{5'd30, 2'd3, FN_T0C0, 1'b0},
        '{5'd30, 2'd2, FN_RSVD, 1'b0}, '{5'd31, 2'd1, FN_RSVD, 1'b0},
        '{5'd31, 2'd3, FN_RSVD, 1'b0}, '{5'd26, 2'd0, FN_RSVD, 1'b0},
        '{5'd22, 2'd3, FN_T0M0, 1'b1}, '{5'd5, 2'd0, FN_GPIO, 1'b0}
    };
    logic                clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, perActive;
    logic [31:0]         haddr, hwdata, hrdata, selLow, selHigh, rd;
    logic [1:0]          htrans;
    logic [NUM_PINS-1:0] gpioOut, gpioDirectionBits, gpioIn, pinIn, pinOut, pinOe, extLevel;
    logic [NUM_FN-1:0]   perOut, perOe, perIn, drvFn;
    int                  errors, checks_done, p;
    logic                expOe;
    logic [NUM_FN-1:0]   expIn;

    initial clk = 1'b0;
    always #50 clk = ~clk;
    assign hready = hreadyout;

    pfs_pin_mux dut_u (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpioOut(gpioOut),
        .gpioDirectionBits(gpioDirectionBits), .gpioIn(gpioIn), .perOut(perOut),
        .perOe(perOe), .perIn(perIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
    pfs_periph_model peri_u (.perActive(perActive), .drvFn(drvFn), .extLevel(extLevel),
        .pinOut(pinOut), .pinOe(pinOe), .perOut(perOut), .perOe(perOe), .pinIn(pinIn));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                print_verdict();
            end
            @(posedge clk);
        end
    endtask : wait_ready

    // one single word transfer; the answer is taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= addr;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wdata;
        wait_ready();
        rdata = hrdata;
    endtask : bus

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // whole-word write from the shadow copy, then two edges for the pins to follow
    task automatic set_field(input int pin, input logic [1:0] code);
        if (pin < 16) begin
            selLow[2*pin +: 2] = code;
            bus(1'b1, PIN_SELECT_LOW_ADDR, selLow, rd);
        end else begin
            selHigh[2*(pin-16) +: 2] = code;
            bus(1'b1, PIN_SELECT_HIGH_ADDR, selHigh, rd);
        end
        settle(2);
    endtask : set_field

    initial begin
        reset_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
        gpioOut = '0; gpioDirectionBits = '0; perActive = 1'b0; drvFn = '0; extLevel = '0;
        selLow = '0;
        selHigh = '0;
        selHigh[27:22] = 6'b010101;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, PIN_SELECT_LOW_ADDR, '0, rd);
        check("low after reset", rd, selLow);
        bus(1'b0, PIN_SELECT_HIGH_ADDR, '0, rd);
        check("high after reset", rd, selHigh);
        check("pinOe after reset", pinOe, '0);
        // write then read with an idle cycle between, then an unmapped place
        bus(1'b1, PIN_SELECT_LOW_ADDR, 32'h55555555, rd);
        bus(1'b0, PIN_SELECT_LOW_ADDR, '0, rd);
        check("low readback", rd, 32'h55555555);
        bus(1'b1, PIN_SELECT_HIGH_ADDR, 32'h15454555, rd);
        bus(1'b1, 32'he002c008, 32'hffffffff, rd);
        bus(1'b0, 32'he002c008, '0, rd);
        check("unmapped read", rd, '0);
        bus(1'b0, PIN_SELECT_HIGH_ADDR, '0, rd);
        check("high readback", rd, 32'h15454555);
        bus(1'b1, PIN_SELECT_LOW_ADDR, selLow, rd);
        bus(1'b1, PIN_SELECT_HIGH_ADDR, selHigh, rd);
        @(posedge clk);
        extLevel <= 32'h0f0f1234;
        settle(4);
        check("gpioIn", gpioIn, 32'h0f0f1234);
        // direction bits must reach only pins that sit on gpio
        @(posedge clk);
        gpioDirectionBits <= '1;
        gpioOut <= 32'h3c3ca5a5;
        settle(2);
        check("pinOe gpio dir", pinOe, 32'h43ffffff);
        check("pinOut gpio", pinOut, 32'h3c3ca5a5 & 32'h43ffffff);
        @(posedge clk);
        gpioOut <= '1;
        perActive <= 1'b1;
        foreach (CASES[i]) begin
            p = CASES[i].pin;
            set_field(p, CASES[i].code);
            @(posedge clk);
            drvFn <= (CASES[i].fn == FN_RSVD) ? '1 : (CASES[i].drives ? 55'd1 << CASES[i].fn : '0);
            extLevel <= '0;
            settle(2);
            expOe = CASES[i].drives || (CASES[i].fn == FN_GPIO);
            check("pinOe case", pinOe[p], expOe);
            check("pinOut case", pinOut[p], expOe);
            @(posedge clk);
            drvFn <= '0;
            extLevel <= 32'd1 << p;
            settle(4);
            expIn = (CASES[i].fn > FN_GPIO) ? 55'd1 << CASES[i].fn : '0;
            check("perIn case", perIn, expIn);
            set_field(p, (p == 30) ? 2'd0 : 2'd0);
        end
        // two pins feeding one external interrupt input
        set_field(1, 2'd3);
        set_field(16, 2'd1);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            extLevel <= (k == 0) ? 32'h00010000 : ((k == 1) ? 32'h00000002 : '0);
            settle(4);
            check("shared input", perIn[FN_XIR0], k < 2);
        end
        print_verdict();
    end
endmodule : tb_port0_pin_function_select
